// ---- core/datapath_slice_buffers.sv ----
// Purpose: One 32-bit data path slice with merge/read, I/O write/DMA
//  read, DMA write and memory write buffers and system bus selectors.
// Assumes: All strobes and buses are synchronous to core_clk_i.
// Notes: Every load or unload takes effect at one rising edge.
`timescale 1ns/1ps

module datapath_slice_buffers
(
	input wire logic core_clk_i,                   // 40 MHz clock
	input wire logic reset_i,                      // Sync reset, high
	input wire slice_pkg::lw_t sys_wr_i,           // Processor write lane
	input wire slice_pkg::lw_t mem_rd_i,           // Memory/cache read
	input wire slice_pkg::cmc_ctl_t cmc_i,         // Memory ctl strobes
	input wire slice_pkg::ioc_ctl_t ioc_i,         // I/O ctl strobes
	input wire logic [31:0] io_data_i,             // I/O bus pin in
	input wire logic [3:0] io_mask_i,              // I/O byte masks in
	output logic [31:0] io_data_o,                 // I/O bus pin out
	output logic io_data_oe_o,                     // I/O bus drive
	output slice_pkg::lw_t sys_lo_o,               // System share low
	output slice_pkg::lw_t sys_hi_o,               // System share high
	output slice_pkg::lw_t mem_wr_o,               // Memory write lane
	output logic mem_wr_vld_o,                     // Memory write valid
	output logic dma_rd_perr_o                     // DMA read par error
);
	import slice_pkg::*;

	// Byte parity of a longword
	function automatic logic [3:0] par_gen(input logic [31:0] d);
		logic [3:0] p;
		p = RST_NIB;
		for (int b = 0; b < BYTES; b++)
			p[b] = ^d[8*b +: 8] ^ PAR_ODD;
		return p;
	endfunction

	// Bytes of n where mask is set, else bytes of o
	function automatic logic [31:0] byte_merge(input logic [31:0] n,
		input logic [31:0] o, input logic [3:0] m);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < BYTES; b++)
			if (m[b])
				r[8*b +: 8] = n[8*b +: 8];
		return r;
	endfunction

	// Storage
	lw_t merge_r [BUF_LW];
	logic [31:0] iodr_r [BUF_ENT][USED_LW];
	io_word_t dwb_r [BUF_ENT][USED_LW];
	lw_t mwb_r [BUF_ENT][BUF_LW];
	logic [31:0] io_data_r;
	logic io_oe_r;
	lw_t sys_lo_r;
	lw_t mem_wr_r;
	logic mem_vld_r;
	logic perr_r;

	// Merge buffer write: processor bytes or I/O read longword
	wire lw_t merge_cur = merge_r[cmc_i.merge_idx];
	wire logic [31:0] merge_dat = byte_merge(sys_wr_i.data,
		merge_cur.data, cmc_i.merge_be);
	wire lw_t merge_wr = '{par: par_gen(merge_dat), data: merge_dat};
	wire lw_t ior_wr = '{par: RST_NIB, data: io_data_i};
	wire logic merge_we = cmc_i.merge_ld | ioc_i.ior_ld;
	wire logic [1:0] merge_wi = ioc_i.ior_ld ? ioc_i.ior_idx
		: cmc_i.merge_idx;

	// Merge buffer
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			for (int i = 0; i < BUF_LW; i++)
				merge_r[i] <= '{par: RST_NIB, data: RST_DATA};
		else if (merge_we)
			merge_r[merge_wi] <= ioc_i.ior_ld ? ior_wr : merge_wr;
	end

	// Parity of background/memory read data
	wire logic mem_perr = par_gen(mem_rd_i.data) != mem_rd_i.par;

	// I/O write / DMA read loads; bank guards the entry split
	wire logic ent_bank = ioc_i.line_sel[1];
	wire logic iow_we = cmc_i.iow_ld && ent_bank == IOW_BANK;
	wire logic dmar_we = cmc_i.dmar_ld && ent_bank == DMAR_BANK;
	wire logic iodr_we = iow_we | dmar_we;
	wire logic iodr_wl = dmar_we ? cmc_i.dmar_lw : cmc_i.mwb_lw[0];
	wire logic [31:0] iodr_wd = dmar_we ? mem_rd_i.data : sys_wr_i.data;

	// I/O write / DMA read buffer, indexed by the I/O line select
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			for (int e = 0; e < BUF_ENT; e++)
				for (int l = 0; l < USED_LW; l++)
					iodr_r[e][l] <= RST_DATA;
		else if (iodr_we)
			iodr_r[ioc_i.line_sel][iodr_wl] <= iodr_wd;
	end

	// DMA read parity error, one-cycle pulse to the I/O controller
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			perr_r <= 1'b0;
		else
			perr_r <= dmar_we & mem_perr;
	end

	// Unload onto the I/O side, one cycle after the strobe
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			io_data_r <= RST_DATA;
			io_oe_r <= 1'b0;
		end
		else
		begin
			io_oe_r <= ioc_i.iodr_unld;
			if (ioc_i.iodr_unld)
				io_data_r <= iodr_r[ioc_i.iodr_ent][ioc_i.iodr_lw];
		end
	end

	// DMA write buffer, filled from the I/O side with masks
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			for (int e = 0; e < BUF_ENT; e++)
				for (int l = 0; l < USED_LW; l++)
					dwb_r[e][l] <= '{mask: RST_NIB, data: RST_DATA};
		else if (ioc_i.dwb_ld)
			dwb_r[ioc_i.dwb_ent][ioc_i.dwb_lw] <=
				'{mask: io_mask_i, data: io_data_i};
	end

	// DMA write drain: merge with background; all parity bits inverted when background parity is bad
	wire io_word_t dwb_cur = dwb_r[cmc_i.dwb_ent][cmc_i.dwb_lw];
	wire logic [31:0] dma_dat = byte_merge(dwb_cur.data,
		mem_rd_i.data, dwb_cur.mask);
	wire logic [3:0] dma_par = par_gen(dma_dat)
		^ (mem_perr ? PAR_FLIP : RST_NIB);

	// Memory write buffer load source
	lw_t mwb_wr;
	always_comb
	begin
		unique case (cmc_i.mwb_src)
			MWB_SYS:
				mwb_wr = sys_wr_i;
			MWB_MERGE:
				mwb_wr = merge_r[cmc_i.mwb_lw];
			MWB_DMA:
				mwb_wr = '{par: dma_par, data: dma_dat};
			MWB_NONE:
				mwb_wr = '{par: RST_NIB, data: RST_DATA};
		endcase
	end
	wire logic mwb_we = cmc_i.mwb_src != MWB_NONE;

	// Memory write buffer store
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			for (int e = 0; e < BUF_ENT; e++)
				for (int l = 0; l < BUF_LW; l++)
					mwb_r[e][l] <= '{par: RST_NIB, data: RST_DATA};
		else if (mwb_we)
			mwb_r[cmc_i.mwb_ent][cmc_i.mwb_lw] <= mwb_wr;
	end

	// Memory side unload, one cycle after the strobe
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			mem_wr_r <= '{par: RST_NIB, data: RST_DATA};
			mem_vld_r <= 1'b0;
		end
		else
		begin
			mem_vld_r <= cmc_i.mwb_unld;
			if (cmc_i.mwb_unld)
				mem_wr_r <= mwb_r[cmc_i.mwb_unld_ent][cmc_i.mwb_unld_lw];
		end
	end

	// Level one: source for each longword and its parity
	lw_t lvl1 [BUF_LW];
	genvar k;
	generate
		for (k = 0; k < BUF_LW; k++)
		begin : g_lvl1
			wire out_src_t src = out_src_t'(cmc_i.out_src[k]);
			assign lvl1[k] = src == SRC_MERGE ? merge_r[k]
				: src == SRC_MEMRD ? mem_rd_i
				: src == SRC_MWB ? mwb_r[cmc_i.out_ent][k]
				: '{par: RST_NIB, data: RST_DATA};
		end
	endgenerate

	// Level two: the pair to drive; only the low lane is wired
	wire lw_t pair_lo = lvl1[{cmc_i.out_pair, 1'b0}];
	wire lw_t pair_hi = lvl1[{cmc_i.out_pair, 1'b1}];

	// System output register, low lane of the selected pair
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			sys_lo_r <= '{par: RST_NIB, data: RST_DATA};
		else if (cmc_i.out_en)
			sys_lo_r <= cmc_i.out_pair ? pair_lo : pair_lo;
	end

	// Outputs
	assign io_data_o = io_data_r;
	assign io_data_oe_o = io_oe_r;
	assign sys_lo_o = sys_lo_r;
	assign sys_hi_o = '{par: RST_NIB, data: RST_DATA};
	assign mem_wr_o = mem_wr_r;
	assign mem_wr_vld_o = mem_vld_r;
	assign dma_rd_perr_o = perr_r;

	// Upper lane of the pair is unused in this configuration
	wire logic unused_hi = ^pair_hi;

endmodule

// ---- core/slice_pkg.sv ----
// Purpose: Shared types and constants for the data path slice.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes: Each slice carries one 32-bit longword lane plus byte parity.
package slice_pkg;

	// Longword and buffer geometry
	localparam int LW_W = 32;
	localparam int BYTES = 4;
	localparam int BUF_LW = 4;
	localparam int BUF_ENT = 4;
	localparam int USED_LW = 2;

	// Entry bank split of the I/O write / DMA read buffer
	localparam logic IOW_BANK = 1'b0;
	localparam logic DMAR_BANK = 1'b1;

	// Parity sense: odd parity per byte
	localparam logic PAR_ODD = 1'b1;

	// Values after reset, and the all-bit parity flip mask
	localparam logic [31:0] RST_DATA = 32'h0000_0000;
	localparam logic [3:0] RST_NIB = 4'h0;
	localparam logic [3:0] PAR_FLIP = 4'hF;

	// Data with its byte parity
	typedef struct packed {
		logic [3:0] par;
		logic [31:0] data;
	} lw_t;

	// Data with its byte masks, as stored from the I/O side
	typedef struct packed {
		logic [3:0] mask;
		logic [31:0] data;
	} io_word_t;

	// Level-one source for one output longword
	typedef enum logic [1:0] {SRC_MERGE, SRC_MEMRD, SRC_MWB, SRC_ZERO}
		out_src_t;

	// Source for a memory write buffer load
	typedef enum logic [1:0] {MWB_SYS, MWB_MERGE, MWB_DMA, MWB_NONE}
		mwb_src_t;

	// Strobes from the cache/memory controller
	typedef struct packed {
		logic merge_ld;
		logic [1:0] merge_idx;
		logic [3:0] merge_be;
		logic iow_ld;
		logic dmar_ld;
		logic dmar_lw;
		mwb_src_t mwb_src;
		logic [1:0] mwb_ent;
		logic [1:0] mwb_lw;
		logic mwb_unld;
		logic [1:0] mwb_unld_ent;
		logic [1:0] mwb_unld_lw;
		logic [1:0] dwb_ent;
		logic dwb_lw;
		logic [3:0][1:0] out_src;
		logic [1:0] out_ent;
		logic out_pair;
		logic out_en;
	} cmc_ctl_t;

	// Strobes from the I/O controller
	typedef struct packed {
		logic [1:0] line_sel;
		logic ior_ld;
		logic [1:0] ior_idx;
		logic dwb_ld;
		logic [1:0] dwb_ent;
		logic dwb_lw;
		logic iodr_unld;
		logic [1:0] iodr_ent;
		logic iodr_lw;
	} ioc_ctl_t;

endpackage

// ---- tb/datapath_slice_buffers_bench.sv ----
// Purpose: Self-checking bench for the data path slice.
// Assumes: Odd byte parity, one-cycle registered answers.
// Notes: Unload results are checked by a queue watcher.
`timescale 1ns/1ps
module datapath_slice_buffers_bench;
	import slice_pkg::*;
	logic core_clk_i = 0;
	logic reset_i = 1;
	lw_t sys_wr_i, mem_rd_i, sys_lo_o, sys_hi_o, mem_wr_o;
	cmc_ctl_t c;
	ioc_ctl_t o;
	logic [31:0] io_data_i, io_data_o, d, b, e, mm;
	logic [3:0] io_mask_i;
	logic io_data_oe_o, mem_wr_vld_o, dma_rd_perr_o, bad;
	logic [31:0] qi[$];
	lw_t qm[$];
	int err_total = 0;
	int cmp_count = 0;
	always #12.5 core_clk_i = ~core_clk_i;
	mem_model far (.d_i(b), .bad_i(bad), .rd_o(mem_rd_i));
	datapath_slice_buffers uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.sys_wr_i(sys_wr_i), .mem_rd_i(mem_rd_i), .cmc_i(c), .ioc_i(o),
		.io_data_i(io_data_i), .io_mask_i(io_mask_i), .io_data_o(io_data_o),
		.io_data_oe_o(io_data_oe_o), .sys_lo_o(sys_lo_o), .sys_hi_o(sys_hi_o),
		.mem_wr_o(mem_wr_o), .mem_wr_vld_o(mem_wr_vld_o),
		.dma_rd_perr_o(dma_rd_perr_o));
	// Odd parity per byte
	function automatic logic [3:0] op(input logic [31:0] x);
		for (int i = 0; i < 4; i++)
			op[i] = ~^x[8*i+:8];
	endfunction
	task automatic chk(input string n, input logic [35:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	// One cycle of strobes, then idle
	task go;
		@(posedge core_clk_i);
		#1;
		c = '0;
		c.mwb_src = MWB_NONE;
		o = '0;
	endtask
	task wrap_up;
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watcher takes the oldest note per result
	always @(posedge core_clk_i)
	begin
		#2;
		if (io_data_oe_o === 1'b1)
			chk("io", io_data_o, qi.size() ? qi.pop_front() : 'x);
		if (mem_wr_vld_o === 1'b1)
			chk("mem", mem_wr_o, qm.size() ? qm.pop_front() : 'x);
	end
	initial
	begin
		#10000;
		err_total++;
		wrap_up;
	end
	initial
	begin
		d = $urandom(32'h08507173);
		c = '0;
		c.mwb_src = MWB_NONE;
		o = '0;
		{sys_wr_i, io_data_i, io_mask_i, b, bad} = '0;
		repeat (4) @(posedge core_clk_i);
		#1;
		reset_i = 0;
		go;
		// Full then partial merge into longword 2
		d = $urandom;
		b = $urandom;
		sys_wr_i = {op(d), d};
		c.merge_ld = 1;
		c.merge_idx = 2'h2;
		c.merge_be = 4'hF;
		go;
		sys_wr_i = {op(b), b};
		c.merge_ld = 1;
		c.merge_idx = 2'h2;
		c.merge_be = 4'h5;
		go;
		e = {d[31:24], b[23:16], d[15:8], b[7:0]};
		c.out_en = 1;
		c.out_pair = 1;
		go;
		chk("merge", sys_lo_o, {op(e), e});
		c.out_en = 1;
		c.out_src[0] = SRC_MEMRD;
		go;
		chk("memrd", sys_lo_o, {op(b), b});
		c.out_en = 1;
		c.out_src[0] = SRC_ZERO;
		go;
		chk("zero", sys_lo_o, 36'h0);
		// I/O read data lands in the shared buffer
		io_data_i = d;
		o.ior_ld = 1;
		go;
		c.out_en = 1;
		go;
		chk("ior", sys_lo_o.data, d);
		// I/O write entries 0-1 (bank 0), DMA read entries 2-3 (bank 1)
		for (int k = 0; k < 8; k++)
		begin
			d = $urandom;
			b = d;
			sys_wr_i = {op(d), d};
			bad = k == 5;
			o.line_sel = k[2:1];
			c.iow_ld = !k[2];
			c.mwb_lw = {1'b0, k[0]};
			c.dmar_ld = k[2];
			c.dmar_lw = k[0];
			go;
			chk("perr", dma_rd_perr_o, k == 5);
			qi.push_back(d);
		end
		// Write into a read bank is refused
		sys_wr_i = ~sys_wr_i;
		bad = 0;
		o.line_sel = 2'h2;
		c.iow_ld = 1;
		go;
		for (int k = 0; k < 8; k++)
		begin
			o.iodr_unld = 1;
			o.iodr_ent = k[2:1];
			o.iodr_lw = k[0];
			go;
		end
		// Masked DMA writes over good and spoiled background
		for (int k = 0; k < 2; k++)
		begin
			d = $urandom;
			b = $urandom;
			io_mask_i = $urandom;
			io_data_i = d;
			o.dwb_ld = 1;
			o.dwb_ent = 2'h3;
			o.dwb_lw = k[0];
			go;
			mm = {{8{io_mask_i[3]}}, {8{io_mask_i[2]}},
				{8{io_mask_i[1]}}, {8{io_mask_i[0]}}};
			e = (d & mm) | (b & ~mm);
			bad = k[0];
			c.mwb_src = MWB_DMA;
			c.dwb_ent = 2'h3;
			c.dwb_lw = k[0];
			c.mwb_ent = 2'h1;
			c.mwb_lw = k[1:0];
			go;
			qm.push_back({op(e) ^ {4{k[0]}}, e});
			c.mwb_unld = 1;
			c.mwb_unld_ent = 2'h1;
			c.mwb_unld_lw = k[1:0];
			go;
		end
		// System load of the memory write buffer
		d = $urandom;
		sys_wr_i = {op(d), d};
		c.mwb_src = MWB_SYS;
		c.mwb_ent = 2'h2;
		go;
		c.out_en = 1;
		c.out_ent = 2'h2;
		c.out_src[0] = SRC_MWB;
		qm.push_back({op(d), d});
		c.mwb_unld = 1;
		c.mwb_unld_ent = 2'h2;
		go;
		chk("mwb", sys_lo_o, {op(d), d});
		go;
		go;
		chk("left", qi.size() + qm.size(), 36'h0);
		wrap_up;
	end
endmodule

// ---- tb/mem_model.sv ----
// Purpose: Memory read side partner feeding background data.
// Assumes: Odd parity per byte on memory data.
// Notes: Parity is spoiled on command to provoke errors.
`timescale 1ns/1ps
module mem_model
(
	input wire logic [31:0] d_i,  // Data to return
	input wire logic bad_i,       // Spoil parity
	output slice_pkg::lw_t rd_o   // Read lane
);
	import slice_pkg::*;
	logic [3:0] gp;
	// Odd parity per byte, all bits inverted on request
	assign gp = {~^d_i[31:24], ~^d_i[23:16], ~^d_i[15:8], ~^d_i[7:0]};
	assign rd_o = {gp ^ {4{bad_i}}, d_i};
endmodule

// ---- tb/slice_monitor.sv ----
// Purpose: Port assertions for the data path slice.
// Assumes: Odd byte parity, registered outputs.
// Notes: Bound onto the slice below the module.
`timescale 1ns/1ps
module slice_monitor
(
	input wire logic core_clk_i,               // Clock
	input wire logic reset_i,                  // Reset
	input wire slice_pkg::lw_t mem_rd_i,       // Memory read
	input wire slice_pkg::cmc_ctl_t cmc_i,     // Memory strobes
	input wire slice_pkg::ioc_ctl_t ioc_i,     // I/O strobes
	input wire logic [31:0] io_data_o,         // I/O data
	input wire logic io_data_oe_o,             // I/O drive
	input wire slice_pkg::lw_t sys_lo_o,       // Low lane
	input wire slice_pkg::lw_t sys_hi_o,       // High lane
	input wire slice_pkg::lw_t mem_wr_o,       // Memory write
	input wire logic mem_wr_vld_o,             // Write valid
	input wire logic dma_rd_perr_o             // Parity error
);
	import slice_pkg::*;
	logic [1:0] sel;
	logic [3:0] gp;
	logic bg_bad;
	// Selected longword and background parity state
	assign sel = {cmc_i.out_pair, 1'b0};
	assign gp = {~^mem_rd_i.data[31:24], ~^mem_rd_i.data[23:16],
		~^mem_rd_i.data[15:8], ~^mem_rd_i.data[7:0]};
	assign bg_bad = gp != mem_rd_i.par;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	hi_zero_a: assert property (sys_hi_o == '0)
		else $error("high lane not zero");
	unld_oe_a: assert property (ioc_i.iodr_unld |=> io_data_oe_o)
		else $error("no drive after unload");
	oe_quiet_a: assert property (!ioc_i.iodr_unld |=>
		!io_data_oe_o && $stable(io_data_o)) else $error("stray drive");
	wr_valid_a: assert property (cmc_i.mwb_unld |=> mem_wr_vld_o)
		else $error("no valid after unload");
	wr_quiet_a: assert property (!cmc_i.mwb_unld |=>
		!mem_wr_vld_o && $stable(mem_wr_o)) else $error("stray write");
	perr_set_a: assert property (cmc_i.dmar_ld && ioc_i.line_sel[1]
		|=> dma_rd_perr_o == $past(bg_bad)) else $error("bad error flag");
	perr_quiet_a: assert property (!cmc_i.dmar_ld |=> !dma_rd_perr_o)
		else $error("stray error flag");
	lo_hold_a: assert property (!cmc_i.out_en |=> $stable(sys_lo_o))
		else $error("low lane moved");
	lo_memrd_a: assert property (cmc_i.out_en &&
		cmc_i.out_src[sel] == SRC_MEMRD |=> sys_lo_o == $past(mem_rd_i))
		else $error("memory source wrong");
	lo_zero_a: assert property (cmc_i.out_en &&
		cmc_i.out_src[sel] == SRC_ZERO |=> sys_lo_o == '0)
		else $error("zero source wrong");
	cover property (cmc_i.mwb_unld);
	cover property (dma_rd_perr_o);
	cover property (ioc_i.iodr_unld ##1 ioc_i.iodr_unld);
endmodule
bind datapath_slice_buffers slice_monitor mon (.core_clk_i(core_clk_i),
	.reset_i(reset_i), .mem_rd_i(mem_rd_i), .cmc_i(cmc_i), .ioc_i(ioc_i),
	.io_data_o(io_data_o), .io_data_oe_o(io_data_oe_o), .sys_lo_o(sys_lo_o),
	.sys_hi_o(sys_hi_o), .mem_wr_o(mem_wr_o), .mem_wr_vld_o(mem_wr_vld_o),
	.dma_rd_perr_o(dma_rd_perr_o));
